// ==== verilog/rsp_map.svh ====
/*
  Constants of the multi-drop slave serial port: reset values, ranges,
  field codes and timing figures.
  Assumes inclusion by the package only, by bare name.
*/
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH

`define RSP_CLK_HZ     100000000
`define RSP_MS_PER_S   1000
`define RSP_BAUD_BASE  1200
`define RSP_GAP_BITS   40

`define RSP_ADDR_RST   8'h01
`define RSP_ADDR_MIN   8'h01
`define RSP_ADDR_MAX   8'hFA
`define RSP_PROTO_RST  1'h0
`define RSP_PROTO_BIN  1'h0
`define RSP_RATE_RST   3'h3
`define RSP_RATE_MAX   3'h5
`define RSP_FMT_RST    2'h0
`define RSP_FMT_8N1    2'h0
`define RSP_FMT_8N2    2'h1
`define RSP_FMT_8E1    2'h2
`define RSP_FMT_8O1    2'h3
`define RSP_DELAY_RST  7'h05
`define RSP_DELAY_MIN  7'h02
`define RSP_DELAY_MAX  7'h64

`define RSP_CRC_INIT   16'hFFFF
`define RSP_CRC_POLY   16'hA001
`define RSP_CHR_ENQ    8'h05
`define RSP_CHR_EOT    8'h04
`define RSP_BIN_MIN_N  8'h04
`define RSP_ASC_MIN_N  8'h05

`endif

// ==== verilog/rsp_pkg.sv ====
/*
  Types and shared functions of the slave serial port.
  Assumes rsp_map.svh is on the include path.
*/
package rsp_pkg;
`include "rsp_map.svh"

  typedef struct packed {
    logic [7:0] addr;
    logic       proto;
    logic [2:0] rate;
    logic [1:0] fmt;
    logic [6:0] delay;
  } rsp_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } rsp_char_t;

  typedef enum logic [2:0] {
    RSP_B_IDLE, RSP_B_START, RSP_B_DATA, RSP_B_PAR, RSP_B_STOP
  } rsp_bit_st_t;

  typedef enum logic [1:0] {
    RSP_LK_LISTEN, RSP_LK_WAIT, RSP_LK_SEND
  } rsp_link_st_t;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] rsp_bit_div(input logic [2:0] code,
                                              input int         clk_hz);
    int d;
    d = clk_hz / (`RSP_BAUD_BASE << code);
    return 17'(d);
  endfunction : rsp_bit_div

  function automatic logic rsp_par(input logic [7:0] d,
                                   input logic [1:0] fmt);
    return (^d) ^ (fmt == `RSP_FMT_8O1);
  endfunction : rsp_par

  function automatic logic [7:0] rsp_hex(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : rsp_hex

  function automatic logic [15:0] rsp_crc(input logic [15:0] c,
                                          input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RSP_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : rsp_crc

endpackage : rsp_pkg

// ==== verilog/rsp_rx_char.sv ====
/*
  Character receiver: start bit, 8 data bits, optional parity, stop.
  Assumes rxd_s is already synchronised to clock.
*/
module rsp_rx_char import rsp_pkg::*; #(
  parameter int CLK_HZ = `RSP_CLK_HZ
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic rxd_s,
  input  wire logic enable,
  input  rsp_cfg_t  cfg,
  output rsp_char_t chr,
  output logic      busy
);

  rsp_bit_st_t st_r, st_nxt;
  logic [16:0] cnt_r, cnt_nxt, div;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        perr_r, perr_nxt, busy_nxt;
  rsp_char_t   chr_nxt;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    div      = rsp_bit_div(cfg.rate, CLK_HZ);
    st_nxt   = st_r;
    cnt_nxt  = (cnt_r == 17'h0) ? div - 17'h1 : cnt_r - 17'h1;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    perr_nxt = perr_r;
    chr_nxt  = '{valid: 1'b0, err: 1'b0, data: sh_r};
    unique case (st_r)
      RSP_B_IDLE: begin
        cnt_nxt = div >> 1;
        if (enable && !rxd_s) begin
          st_nxt   = RSP_B_START;
          perr_nxt = 1'b0;
        end
      end
      RSP_B_START: if (cnt_r == 17'h0) begin
        // Mid-bit recheck rejects glitches
        st_nxt  = rxd_s ? RSP_B_IDLE : RSP_B_DATA;
        bit_nxt = 3'h0;
      end
      RSP_B_DATA: if (cnt_r == 17'h0) begin
        sh_nxt  = {rxd_s, sh_r[7:1]};
        bit_nxt = bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          st_nxt = cfg.fmt[1] ? RSP_B_PAR : RSP_B_STOP;
        end
      end
      RSP_B_PAR: if (cnt_r == 17'h0) begin
        perr_nxt = rxd_s != rsp_par(sh_r, cfg.fmt);
        st_nxt   = RSP_B_STOP;
      end
      RSP_B_STOP: if (cnt_r == 17'h0) begin
        // Only the first stop bit is checked; a second is line idle
        chr_nxt = '{valid: 1'b1, err: perr_r | !rxd_s, data: sh_r};
        st_nxt  = RSP_B_IDLE;
      end
      default: st_nxt = RSP_B_IDLE;
    endcase
    busy_nxt = st_nxt != RSP_B_IDLE;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r   <= RSP_B_IDLE;
      cnt_r  <= 17'h0;
      bit_r  <= 3'h0;
      sh_r   <= 8'h00;
      perr_r <= 1'b0;
      chr    <= '0;
      busy   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      perr_r <= perr_nxt;
      chr    <= chr_nxt;
      busy   <= busy_nxt;
    end
  end

endmodule : rsp_rx_char

// ==== verilog/rsp_slave_port.sv ====
/*
  Half-duplex multi-drop slave serial port: configuration, request
  reception and checking, response delay and response transmission.
  Assumes an external line transceiver driven by txd and txd_oe, and a
  user that supplies response bytes after frame_ok.
*/
// How it works
// - Master starts exchanges; port only answers requests
// - Start-stop characters, half duplex on one pair
// - Six rates, 1200 to 38400 bit/s
// - Binary characters or printable ASCII characters
// - One or two stop bits per format
// - None, even or odd parity, checked on receive
// - Two-byte CRC (binary) or hex-coded byte sum (ASCII) verified before acting
// - Station address 1 to 250, default 1
// - Rate codes 0 to 5, default code 3
// - Format codes 0 to 3, default 8N1
// - Answer waits configured 2 to 100 ms
module rsp_slave_port import rsp_pkg::*; #(
  parameter int CLK_HZ = `RSP_CLK_HZ
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic rxd,
  output logic      txd,
  output logic      txd_oe,
  input  wire logic cfg_load,
  input  rsp_cfg_t  cfg_in,
  output rsp_cfg_t  cfg_q,
  output rsp_char_t rx_char,
  output logic      frame_ok,
  output logic      frame_bad,
  input  wire logic resp_valid,
  input  wire logic [7:0] resp_data,
  input  wire logic resp_last,
  output logic      resp_ready
);

  localparam int MS_CYC = CLK_HZ / `RSP_MS_PER_S;

  logic         s1_r, s2_r, rx_busy;
  rsp_char_t    chr;
  rsp_cfg_t     cfg_nxt;
  logic [16:0]  div;
  logic [21:0]  gap_r, gap_nxt, gap_lim;
  logic [7:0]   n_r, n_nxt, h1_r, h1_nxt, h2_r, h2_nxt, sum_r, sum_nxt;
  logic [15:0]  crc_r, crc_nxt;
  logic         idok_r, idok_nxt, bad_r, bad_nxt;
  logic         ok_nxt, fbad_nxt, rx_en;
  rsp_char_t    rxo_nxt;
  logic         asc;

  rsp_link_st_t lk_r, lk_nxt;
  rsp_bit_st_t  tx_r, tx_nxt;
  logic [16:0]  tcnt_r, tcnt_nxt, dly_r, dly_nxt;
  logic [6:0]   ms_r, ms_nxt;
  logic [2:0]   tbit_r, tbit_nxt;
  logic [7:0]   tsh_r, tsh_nxt;
  logic         tpar_r, tpar_nxt, stop2_r, stop2_nxt, last_r, last_nxt;
  logic         txd_nxt, oe_nxt, rdy_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= rxd;
      s2_r <= s1_r;
    end
  end

  // Own transmissions are not listened to
  assign rx_en = lk_r != RSP_LK_SEND;

  rsp_rx_char #(.CLK_HZ(CLK_HZ)) u_rx (
    .clock   (clock),
    .sys_rst (sys_rst),
    .rxd_s   (s2_r),
    .enable  (rx_en),
    .cfg     (cfg_q),
    .chr     (chr),
    .busy    (rx_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Configuration and request checking
  always_comb begin
    cfg_nxt = cfg_q;
    if (cfg_load) begin
      // Out-of-range values are ignored, keeping the old setting
      if (cfg_in.addr >= `RSP_ADDR_MIN && cfg_in.addr <= `RSP_ADDR_MAX)
        cfg_nxt.addr = cfg_in.addr;
      if (cfg_in.rate <= `RSP_RATE_MAX)
        cfg_nxt.rate = cfg_in.rate;
      if (cfg_in.delay >= `RSP_DELAY_MIN && cfg_in.delay <= `RSP_DELAY_MAX)
        cfg_nxt.delay = cfg_in.delay;
      cfg_nxt.proto = cfg_in.proto;
      cfg_nxt.fmt   = cfg_in.fmt;
    end
    asc      = cfg_q.proto != `RSP_PROTO_BIN;
    div      = rsp_bit_div(cfg_q.rate, CLK_HZ);
    gap_lim  = 22'(`RSP_GAP_BITS * int'(div));
    gap_nxt  = (rx_busy || !s2_r) ? 22'h0 :
               (gap_r == gap_lim) ? gap_r : gap_r + 22'h1;
    n_nxt    = n_r;
    h1_nxt   = h1_r;
    h2_nxt   = h2_r;
    sum_nxt  = sum_r;
    crc_nxt  = crc_r;
    idok_nxt = idok_r;
    bad_nxt  = bad_r;
    ok_nxt   = 1'b0;
    fbad_nxt = 1'b0;
    rxo_nxt  = chr;
    if (chr.valid && !asc) begin
      crc_nxt  = rsp_crc(crc_r, chr.data);
      bad_nxt  = bad_r | chr.err;
      if (n_r == 8'h00) idok_nxt = chr.data == cfg_q.addr;
      if (n_r != 8'hFF) n_nxt = n_r + 8'h01;
    end else if (chr.valid) begin
      if (chr.data == `RSP_CHR_ENQ) begin
        n_nxt    = 8'h01;
        sum_nxt  = 8'h00;
        bad_nxt  = chr.err;
        idok_nxt = 1'b1;
      end else if (n_r != 8'h00 && chr.data == `RSP_CHR_EOT) begin
        // Last two characters hold the sum in hex
        ok_nxt   = !bad_r && !chr.err && idok_r && n_r >= `RSP_ASC_MIN_N
                   && h2_r == rsp_hex(sum_r[7:4])
                   && h1_r == rsp_hex(sum_r[3:0]);
        fbad_nxt = !ok_nxt && idok_r;
        n_nxt    = 8'h00;
      end else if (n_r != 8'h00) begin
        bad_nxt = bad_r | chr.err;
        if (n_r >= 8'h03) sum_nxt = sum_r + h2_r;
        if (n_r == 8'h01)
          idok_nxt = idok_r && chr.data == rsp_hex(cfg_q.addr[7:4]);
        if (n_r == 8'h02)
          idok_nxt = idok_r && chr.data == rsp_hex(cfg_q.addr[3:0]);
        h2_nxt = h1_r;
        h1_nxt = chr.data;
        if (n_r != 8'hFF) n_nxt = n_r + 8'h01;
      end
    end
    // Line silence closes a binary frame and aborts an ASCII one
    if (gap_nxt == gap_lim && gap_r != gap_lim && n_r != 8'h00) begin
      if (!asc) begin
        ok_nxt   = !bad_r && idok_r && n_r >= `RSP_BIN_MIN_N
                   && crc_r == 16'h0000;
        fbad_nxt = !ok_nxt && (idok_r || bad_r);
      end
      n_nxt = 8'h00;
    end
    if (n_nxt == 8'h00) begin
      crc_nxt = `RSP_CRC_INIT;
      bad_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_q.addr  <= `RSP_ADDR_RST;
      cfg_q.proto <= `RSP_PROTO_RST;
      cfg_q.rate  <= `RSP_RATE_RST;
      cfg_q.fmt   <= `RSP_FMT_RST;
      cfg_q.delay <= `RSP_DELAY_RST;
      gap_r       <= 22'h0;
      n_r         <= 8'h00;
      h1_r        <= 8'h00;
      h2_r        <= 8'h00;
      sum_r       <= 8'h00;
      crc_r       <= `RSP_CRC_INIT;
      idok_r      <= 1'b0;
      bad_r       <= 1'b0;
      frame_ok    <= 1'b0;
      frame_bad   <= 1'b0;
      rx_char     <= '0;
    end else begin
      cfg_q       <= cfg_nxt;
      gap_r       <= gap_nxt;
      n_r         <= n_nxt;
      h1_r        <= h1_nxt;
      h2_r        <= h2_nxt;
      sum_r       <= sum_nxt;
      crc_r       <= crc_nxt;
      idok_r      <= idok_nxt;
      bad_r       <= bad_nxt;
      frame_ok    <= ok_nxt;
      frame_bad   <= fbad_nxt;
      rx_char     <= rxo_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response delay and transmitter
  always_comb begin
    lk_nxt    = lk_r;
    tx_nxt    = tx_r;
    tcnt_nxt  = (tcnt_r == 17'h0) ? div - 17'h1 : tcnt_r - 17'h1;
    dly_nxt   = dly_r;
    ms_nxt    = ms_r;
    tbit_nxt  = tbit_r;
    tsh_nxt   = tsh_r;
    tpar_nxt  = tpar_r;
    stop2_nxt = stop2_r;
    last_nxt  = last_r;
    txd_nxt   = txd;
    oe_nxt    = txd_oe;
    rdy_nxt   = resp_ready;
    unique case (lk_r)
      RSP_LK_LISTEN: begin
        dly_nxt = 17'h0;
        ms_nxt  = 7'h00;
        if (frame_ok) lk_nxt = RSP_LK_WAIT;
      end
      RSP_LK_WAIT: begin
        dly_nxt = (dly_r == 17'(MS_CYC - 1)) ? 17'h0 : dly_r + 17'h1;
        if (dly_r == 17'(MS_CYC - 1)) ms_nxt = ms_r + 7'h01;
        // A new request supersedes a pending answer
        if (rx_busy) begin
          lk_nxt = RSP_LK_LISTEN;
        end else if (ms_r == cfg_q.delay) begin
          lk_nxt  = RSP_LK_SEND;
          oe_nxt  = 1'b1;
          rdy_nxt = 1'b1;
          tx_nxt  = RSP_B_IDLE;
        end
      end
      RSP_LK_SEND: begin
        unique case (tx_r)
          RSP_B_IDLE: if (resp_valid && resp_ready) begin
            tsh_nxt   = resp_data;
            tpar_nxt  = rsp_par(resp_data, cfg_q.fmt);
            last_nxt  = resp_last;
            rdy_nxt   = 1'b0;
            txd_nxt   = 1'b0;
            tcnt_nxt  = div - 17'h1;
            tx_nxt    = RSP_B_START;
          end
          RSP_B_START: if (tcnt_r == 17'h0) begin
            txd_nxt  = tsh_r[0];
            tbit_nxt = 3'h0;
            tx_nxt   = RSP_B_DATA;
          end
          RSP_B_DATA: if (tcnt_r == 17'h0) begin
            tsh_nxt  = tsh_r >> 1;
            tbit_nxt = tbit_r + 3'h1;
            txd_nxt  = tsh_r[1];
            if (tbit_r == 3'h7) begin
              txd_nxt   = cfg_q.fmt[1] ? tpar_r : 1'b1;
              tx_nxt    = cfg_q.fmt[1] ? RSP_B_PAR : RSP_B_STOP;
              stop2_nxt = cfg_q.fmt == `RSP_FMT_8N2;
            end
          end
          RSP_B_PAR: if (tcnt_r == 17'h0) begin
            txd_nxt   = 1'b1;
            stop2_nxt = 1'b0;
            tx_nxt    = RSP_B_STOP;
          end
          RSP_B_STOP: if (tcnt_r == 17'h0) begin
            if (stop2_r) begin
              stop2_nxt = 1'b0;
            end else if (last_r) begin
              oe_nxt = 1'b0;
              tx_nxt = RSP_B_IDLE;
              lk_nxt = RSP_LK_LISTEN;
            end else begin
              rdy_nxt = 1'b1;
              tx_nxt  = RSP_B_IDLE;
            end
          end
          default: tx_nxt = RSP_B_IDLE;
        endcase
      end
      default: lk_nxt = RSP_LK_LISTEN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lk_r       <= RSP_LK_LISTEN;
      tx_r       <= RSP_B_IDLE;
      tcnt_r     <= 17'h0;
      dly_r      <= 17'h0;
      ms_r       <= 7'h00;
      tbit_r     <= 3'h0;
      tsh_r      <= 8'h00;
      tpar_r     <= 1'b0;
      stop2_r    <= 1'b0;
      last_r     <= 1'b0;
      txd        <= 1'b1;
      txd_oe     <= 1'b0;
      resp_ready <= 1'b0;
    end else begin
      lk_r       <= lk_nxt;
      tx_r       <= tx_nxt;
      tcnt_r     <= tcnt_nxt;
      dly_r      <= dly_nxt;
      ms_r       <= ms_nxt;
      tbit_r     <= tbit_nxt;
      tsh_r      <= tsh_nxt;
      tpar_r     <= tpar_nxt;
      stop2_r    <= stop2_nxt;
      last_r     <= last_nxt;
      txd        <= txd_nxt;
      txd_oe     <= oe_nxt;
      resp_ready <= rdy_nxt;
    end
  end

endmodule : rsp_slave_port

// ==== verif/rsp_slave_port_properties.sv ====
/*
  Pin checker of the slave serial port.
  Assumes a bind from the bench onto rsp_slave_port.
*/
module rsp_port_chk import rsp_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic cfg_load,
  input rsp_cfg_t  cfg_in,
  input rsp_cfg_t  cfg_q,
  input wire logic frame_ok,
  input wire logic frame_bad,
  input wire logic resp_valid,
  input wire logic resp_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic seen_r;
  logic seen_nxt;
  logic oe_r;
  //////////////////////////////////////////////////////////////////////////
  // Cancelled waits leave it set: a weak but safe bound
  always_comb begin
    seen_nxt = frame_ok | (seen_r & ~(oe_r & ~txd_oe));
  end
  always_ff @(posedge clock) begin
    seen_r <= sys_rst ? 1'b0 : seen_nxt;
    oe_r   <= txd_oe;
  end
  //////////////////////////////////////////////////////////////////////////
  chk_reset_idle: assert property (disable iff (1'b0)
    sys_rst |=> txd && !txd_oe && !resp_ready && !frame_ok && !frame_bad)
    else $error("outputs not idle after reset");
  chk_cfg_addr: assert property (
    cfg_load |=> cfg_q.addr == ($past(cfg_in.addr) inside {[8'h01:8'hFA]}
      ? $past(cfg_in.addr) : $past(cfg_q.addr)))
    else $error("station address load wrong");
  chk_cfg_rate: assert property (
    cfg_load |=> cfg_q.rate == (($past(cfg_in.rate) <= 3'h5)
      ? $past(cfg_in.rate) : $past(cfg_q.rate)))
    else $error("rate load wrong");
  chk_cfg_delay: assert property (
    cfg_load |=> cfg_q.delay == ($past(cfg_in.delay) inside {[7'h02:7'h64]}
      ? $past(cfg_in.delay) : $past(cfg_q.delay)))
    else $error("delay load wrong");
  chk_cfg_fmt: assert property (
    cfg_load |=> cfg_q.fmt == $past(cfg_in.fmt)
      && cfg_q.proto == $past(cfg_in.proto))
    else $error("format or protocol load wrong");
  chk_ask_first: assert property ($rose(txd_oe) |-> seen_r)
    else $error("driver enabled without request");
  chk_idle_high: assert property (!txd_oe |-> txd)
    else $error("line low while released");
  chk_oe_stop: assert property (
    $fell(txd_oe) |-> $past(txd, 1) && $past(txd, 8))
    else $error("release not after stop bit");
  chk_ready_oe: assert property (resp_ready |-> txd_oe)
    else $error("ready outside answer");
  chk_take_start: assert property (
    resp_valid && resp_ready |=> !txd && !resp_ready && txd_oe)
    else $error("start bit missing after take");
  chk_ok_excl: assert property (!(frame_ok && frame_bad))
    else $error("frame good and bad at once");
endmodule : rsp_port_chk

// ==== verif/rsp_master_model.sv ====
/*
  Master station model: sends request characters on rxd and
  collects answer characters off the bus.
  Assumes cfg mirrors the settings loaded into the port.
*/
module rsp_master_model import rsp_pkg::*; #(
  parameter int CLK_HZ = 614400
) (
  input wire logic clock,
  input rsp_cfg_t  cfg,
  input wire logic txd,
  input wire logic txd_oe,
  output logic     rxd
);
  logic       bad_par;
  logic [7:0] b;
  logic [7:0] rx_q[$];
  int         rx_err;
  // Bias resistors hold a released bus high
  wire logic  line = txd_oe ? txd : 1'b1;
  //////////////////////////////////////////////////////////////////////////
  function automatic int dv();
    return CLK_HZ / (1200 << cfg.rate);
  endfunction : dv
  task automatic bit_out(input logic v);
    rxd = v;
    repeat (dv()) @(negedge clock);
  endtask : bit_out
  // Only the bench calls this: master starts exchanges
  task automatic send_byte(input logic [7:0] d);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (cfg.fmt[1]) bit_out(^d ^ cfg.fmt[0] ^ bad_par);
    bit_out(1'b1);
    if (cfg.fmt == 2'h1) bit_out(1'b1);
  endtask : send_byte
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rxd = 1'b1;
    bad_par = 1'b0;
    rx_err = 0;
    forever begin
      @(negedge clock);
      if (!line) begin
        repeat (dv() / 2) @(negedge clock);
        for (int i = 0; i < 9; i++) begin
          repeat (dv()) @(negedge clock);
          if (i < 8) b[i] = line;
        end
        if (cfg.fmt[1] && line !== (^b ^ cfg.fmt[0])) rx_err++;
        if (!cfg.fmt[1] && line !== 1'b1) rx_err++;
        // Last stop bit of formats 1 to 3 seen high with the driver still on
        // Parity formats still owe their stop bit after the parity bit
        repeat (cfg.fmt != 2'h0 ? 1 : 0) begin
          repeat (dv()) @(negedge clock);
          if (line !== 1'b1 || txd_oe !== 1'b1) rx_err++;
        end
        rx_q.push_back(b);
      end
    end
  end
endmodule : rsp_master_model

// ==== verif/rsp_slave_port_tb.sv ====
/*
  Bench of the slave serial port: master model on the line, user
  answers on the response port. Assumes the checker is compiled.
*/
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module rsp_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsp_pkg::*;
  // Small clock keeps bit and ms counts short
  localparam int CLK = 614400;
  localparam int MS  = CLK / 1000;
  logic       clock, sys_rst, rxd, txd, txd_oe, cfg_load;
  logic       frame_ok, frame_bad, resp_valid, resp_last, resp_ready;
  logic [7:0] resp_data, s;
  logic [7:0] q[$];
  logic [31:0] lfsr;
  rsp_cfg_t   cfg_in, cfg_q, cfg;
  rsp_char_t  rx_char, last_c;
  int         err_count, check_count, cyc, ok_cyc, n_ok, n_bad;
  rsp_slave_port #(.CLK_HZ(CLK)) rsp_slave_port_inst (.clock(clock),
    .sys_rst(sys_rst), .rxd(rxd), .txd(txd), .txd_oe(txd_oe),
    .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg_q(cfg_q),
    .rx_char(rx_char), .frame_ok(frame_ok), .frame_bad(frame_bad),
    .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_last(resp_last), .resp_ready(resp_ready));
  rsp_master_model #(.CLK_HZ(CLK)) rsp_master_model_inst (.clock(clock),
    .cfg(cfg), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (frame_ok === 1'b1) n_ok <= n_ok + 1;
    if (frame_ok === 1'b1) ok_cyc <= cyc;
    if (frame_bad === 1'b1) n_bad <= n_bad + 1;
    if (rx_char.valid === 1'b1) last_c <= rx_char;
    if (cyc == 60000) err_count++;
    if (cyc == 60000) stop_test();
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
    return lfsr[7:0];
  endfunction : rnd
  function automatic logic [15:0] fcs(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (d[i]) begin
      c = c ^ {8'h00, d[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : fcs
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hx
  task automatic bits(input int n);
    repeat (n * (CLK / (1200 << cfg.rate))) @(negedge clock);
  endtask : bits
  task automatic do_rst();
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
  endtask : do_rst
  task automatic load(input rsp_cfg_t v);
    cfg_in = v;
    cfg = v;
    cfg_load = 1'b1;
    @(negedge clock);
    cfg_load = 1'b0;
    // Let an edge pass so back-to-back loads stay distinct pulses
    @(negedge clock);
  endtask : load
  task automatic send();
    foreach (q[i]) rsp_master_model_inst.send_byte(q[i]);
  endtask : send
  task automatic frame(input logic [7:0] a, input logic bad);
    logic [15:0] c;
    q = {a, 8'h03, rnd(), rnd()};
    c = fcs(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    send();
    bits(42);
  endtask : frame
  // Polls live signals; a value argument would freeze at call time
  task automatic wt(input bit rdy);
    int w;
    w = 0;
    while (w < 9000 && (rdy ? resp_ready : !txd_oe) !== 1'b1) begin
      w++;
      @(negedge clock);
    end
    if (w == 9000) err_count++;
  endtask : wt
  task automatic answer(input int n);
    logic [7:0] e[$];
    wt(1'b1);
    `CHK("delay", 1'b1, cyc - ok_cyc inside {[2*MS-2:2*MS+8]})
    for (int i = 0; i < n; i++) begin
      e.push_back(rnd());
      resp_data = e[i];
      resp_last = (i == n - 1);
      resp_valid = 1'b1;
      wt(1'b1);
      @(negedge clock);
    end
    resp_valid = 1'b0;
    wt(1'b0);
    `CHK("tx_n", n, rsp_master_model_inst.rx_q.size())
    foreach (e[i]) `CHK("tx_byte", e[i], rsp_master_model_inst.rx_q[i])
    `CHK("tx_err", 0, rsp_master_model_inst.rx_err)
    rsp_master_model_inst.rx_q = {};
  endtask : answer
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {cfg_load, resp_valid, resp_last, resp_data} = '0;
    {err_count, check_count, cyc, ok_cyc, n_ok, n_bad} = '0;
    lfsr = 32'hE4BE91C3;
    cfg_in = {8'h01, 1'h0, 3'h3, 2'h0, 7'h05};
    cfg = cfg_in;
    do_rst();
    `CHK("cfg_rst", cfg_in, cfg_q)
    load({8'h00, 1'h0, 3'h6, 2'h1, 7'h01});
    `CHK("cfg_bad", 21'({8'h01, 1'h0, 3'h3, 2'h1, 7'h05}), cfg_q)
    load({8'hFB, 1'h1, 3'h5, 2'h1, 7'h65});
    `CHK("cfg_bad2", 21'({8'h01, 1'h1, 3'h5, 2'h1, 7'h05}), cfg_q)
    load({8'h2A, 1'h0, 3'h5, 2'h1, 7'h02});
    frame(8'h2A, 1'b0);
    `CHK("ok_own", 1, n_ok)
    answer(2);
    // Second drop on the segment has its own address
    frame(8'h2B, 1'b0);
    `CHK("ok_other", 1, n_ok)
    frame(8'h2A, 1'b1);
    `CHK("bad_crc", 1, n_bad)
    repeat (3 * MS) @(negedge clock);
    `CHK("no_answer", 1'b0, txd_oe)
    for (int f = 2; f < 4; f++) begin
      load({8'h2A, 1'h0, 3'h5, 2'(f), 7'h02});
      for (int p = 0; p < 2; p++) begin
        rsp_master_model_inst.bad_par = p[0];
        rsp_master_model_inst.send_byte(8'h5C);
        bits(1);
        `CHK("par_err", p[0], last_c.err)
      end
    end
    rsp_master_model_inst.bad_par = 1'b0;
    bits(42);
    // Odd parity here so the answer also walks the parity bit path
    load({8'h2A, 1'h1, 3'h5, 2'h3, 7'h02});
    q = {8'h05, 8'h32, 8'h41, 8'h52};
    s = q[1] + q[2] + q[3];
    q = {q, hx(s[7:4]), hx(s[3:0]), 8'h04};
    send();
    bits(1);
    `CHK("ascii_ok", 2, n_ok)
    answer(1);
    do_rst();
    `CHK("cfg_rst2", 21'({8'h01, 1'h0, 3'h3, 2'h0, 7'h05}), cfg_q)
    for (int r = 0; r < 6; r++) begin
      load({8'h01, 1'h0, 3'(r), 2'h0, 7'h05});
      s = rnd();
      rsp_master_model_inst.send_byte(s);
      bits(1);
      `CHK("rate_data", s, last_c.data)
    end
    stop_test();
  end
endmodule : rsp_slave_port_tb
bind rsp_slave_port rsp_port_chk rsp_port_chk_inst (.clock(clock),
  .sys_rst(sys_rst), .txd(txd), .txd_oe(txd_oe), .cfg_load(cfg_load),
  .cfg_in(cfg_in), .cfg_q(cfg_q), .frame_ok(frame_ok),
  .frame_bad(frame_bad), .resp_valid(resp_valid),
  .resp_ready(resp_ready));
